// ---- bench/pdf_pin_function_props.sv ----
/* checker: bus and routing properties
 sees only the block's ports */
`timescale 1ns/100ps
`default_nettype none
module pdf_props (
	input wire logic pclk, presetn, psel, penable, pready, pslverr,
	input wire logic [7:0] paddr, ext_int_line,
	input wire pdf_pkg::pdf_mode_type chip_mode,
	input wire pdf_pkg::pdf_route_type upper_route, low_route
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_set; psel && !penable; endsequence
	AST_RDY: assert property (s_set |=> pready)
		else $error("no ready");
	AST_ONE: assert property (pready |=> !pready)
		else $error("long ready");
	AST_ERR: assert property ((s_set and (paddr > 8'h0c)) |=> pslverr)
		else $error("no error");
	AST_SGL: assert property ($past(presetn) && !$past(chip_mode[0]) |->
		{low_route.bus_sel, upper_route.bus_sel} == 32'h0) else $error("bus in single");
	AST_OFF: assert property ($past(presetn) && $past(chip_mode) == 2'h3 |->
		low_route.bus_sel == 16'hffff) else $error("not forced");
	AST_IRQ: assert property (ext_int_line == upper_route.irq_sel[7:0])
		else $error("channel map");
	AST_LOW: assert property (low_route.irq_sel == 16'h0)
		else $error("low irq");
	AST_EXC: assert property ((upper_route.bus_sel & upper_route.irq_sel) == 16'h0)
		else $error("two uses");
endmodule : pdf_props
bind pdf_pin_function pdf_props pdf_props_inst (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .paddr, .ext_int_line, .chip_mode, .upper_route, .low_route);
`default_nettype wire

// ---- bench/pdf_pin_function_tb.sv ----
/* bench: random and corner routing tests
 assumes a zero-wait APB slave */
`timescale 1ns/100ps
`default_nettype none
module pdf_pin_function_tb;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er;
	logic [7:0] paddr = 8'h0, ext_int_line;
	logic [31:0] pwdata = 32'h0, prdata, rd, x = 34, r, e;
	logic [23:0] bus_pins;
	logic [15:0] u, l;
	pdf_pkg::pdf_mode_type chip_mode = pdf_pkg::PDF_SINGLE_CHIP;
	pdf_pkg::pdf_route_type upper_route, low_route;
	int bad_count = 0, num_checks = 0;
	always #20 pclk = ~pclk;
	pdf_pin_function pdf_pin_function_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .chip_mode, .upper_route,
		.low_route, .ext_int_line);
	pdf_pin_peer pdf_pin_peer_inst (.upper_route, .low_route, .bus_pins);
	task chk(input string n, input logic [31:0] s, c);
		num_checks++;
		if (s !== c) begin
			bad_count++;
			$display("ERROR %s exp %h seen %h", n, c, s);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tally_and_finish
	// idle edge first, so psel is never set twice in one step
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 9);
		if (t == 9) begin
			bad_count++;
			tally_and_finish;
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	function automatic logic [31:0] exp_r(input logic [15:0] u, l, input logic [1:0] m);
		exp_r = 32'h0;
		for (int i = 0; i < 8; i++) begin
			exp_r[24 + i] = u[2 * i +: 2] == 2'h2;
			exp_r[16 + i] = u[2 * i +: 2] == 2'h1 && m[0];
		end
		exp_r[15:0] = m == 2'h3 ? 16'hffff : m == 2'h1 ? l : 16'h0;
	endfunction : exp_r
	function automatic logic [31:0] xs(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xs
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h00, 32'h0);
		chk("upper reg", rd, 32'h0);
		for (int k = 0; k < 10; k++) begin
			x = xs(x);
			r = k == 0 ? 32'h5555aaaa : k == 1 ? 32'hffff5555 : x;
			u = r[15:0] & ~(r[16:1] & r[15:0] & 16'h5555);
			l = r[31:16];
			apb(1, 8'h00, {r[31:16], u});
			apb(1, 8'h04, {r[15:0], l});
			apb(0, 8'h04, 32'h0);
			chk("low reg", rd, {16'h0, l});
			apb(0, 8'h00, 32'h0);
			chk("upper reg", rd, {16'h0, u});
			for (int m = 0; m < 4; m++) begin
				chip_mode <= pdf_pkg::pdf_mode_type'(m);
				repeat (2) @(posedge pclk);
				e = exp_r(u, l, m[1:0]);
				chk("upper", upper_route, {8'h0, e[23:16], 8'h0, e[31:24]});
				chk("bus pins", {8'h0, bus_pins}, {8'h0, e[23:0]});
				chk("channels", {24'h0, ext_int_line}, {24'h0, e[31:24]});
			end
			$display("test %0d done", k);
		end
		apb(0, 8'h0c, 32'h0);
		chk("route readback", rd, {8'h0, e[31:24], e[15:0]});
		apb(0, 8'h08, 32'h0);
		chk("mode readback", rd, 32'h3);
		apb(1, 8'h08, 32'h0);
		chk("read-only write", {31'h0, er}, 32'h1);
		apb(1, 8'h00, 32'h0000ffff);
		repeat (2) @(posedge pclk);
		chk("reserved code", upper_route, 32'h0);
		apb(1, 8'h10, 32'hffffffff);
		chk("unmapped", {31'h0, er}, 32'h1);
		presetn <= 0;
		repeat (2) @(posedge pclk);
		presetn <= 1;
		apb(0, 8'h04, 32'h0);
		chk("low after reset", rd, 32'h0);
		tally_and_finish;
	end
endmodule : pdf_pin_function_tb
`default_nettype wire

// ---- bench/pdf_pin_peer.sv ----
/* partner: pins claimed by external bus devices
 assumes the block's route structs */
`timescale 1ns/100ps
`default_nettype none
module pdf_pin_peer (
	input wire pdf_pkg::pdf_route_type upper_route, low_route,
	output logic [23:0] bus_pins
);
	// bus devices only see pins handed to them
	assign bus_pins = {upper_route.bus_sel[7:0], low_route.bus_sel};
endmodule : pdf_pin_peer
`default_nettype wire

// ---- hdl/pdf_pin_function.sv ----
/*
 * pdf_pin_function: function-select registers and pin routing for port pins 23..0.
 * assumes a synchronous APB master on pclk and a chip mode that is static or slow.
 */
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
// Function
// - upper register: eight 2-bit fields, pin 23 at bits 15:14 down to pin 16
// - code 00 in an upper field routes pin to general I/O; reset value
// - code 01 routes pin to data bus bit, general I/O in single-chip mode
// - code 10 on pin 23 selects interrupt channel 7; code 11 reserved
// - code 10 on pins 22..18 selects channels 6..2
// - code 10 on pins 17,16 selects channels 1,0; channel = pin minus 16
// - low register is 16-bit read/write, bit n controls pin n
// - low bit 0 general I/O, 1 data bus except in single-chip mode
// - rom disabled extended mode forces low pins to data bus, register ignored
// - rom enabled extended mode honours the low register per bit
// - single-chip mode makes all low pins general I/O
// - low register clears only on power-on reset
module pdf_pin_function (
	// clock and power-on reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// chip operating mode
	input wire pdf_pkg::pdf_mode_type chip_mode,
	// pin routing
	output pdf_pkg::pdf_route_type upper_route,
	output pdf_pkg::pdf_route_type low_route,
	output logic [7:0] ext_int_line
);

	// function register state
	logic [15:0] port_d_upper_mid_function;
	logic [15:0] port_d_low_function;
	logic [15:0] next_upper;
	logic [15:0] next_low;

	// bus response state
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;

	// routing state
	pdf_pkg::pdf_route_type next_upper_route;
	pdf_pkg::pdf_route_type next_low_route;
	logic [7:0] next_ext_int_line;

	// transfer phase and address decode
	logic setup;
	logic access;
	logic hit_upper;
	logic hit_low;
	logic hit_mode;
	logic hit_route;
	logic mapped;
	logic read_only;

	// chip mode decode
	logic single;
	logic rom_on;
	logic rom_off;

	// per-pin decoder results
	logic [7:0] upper_bus;
	logic [7:0] upper_irq;
	logic [15:0] low_bus;

	assign setup = psel && !penable;
	// a write lands only on the edge that completes the access phase
	assign access = psel && penable && pready;

	always_comb begin
		hit_upper = 1'b0;
		hit_low = 1'b0;
		hit_mode = 1'b0;
		hit_route = 1'b0;
		case (paddr)
			pdf_pkg::UPPER_MID_ADDR: begin
				hit_upper = 1'b1;
			end
			pdf_pkg::LOW_ADDR: begin
				hit_low = 1'b1;
			end
			pdf_pkg::MODE_ADDR: begin
				hit_mode = 1'b1;
			end
			pdf_pkg::ROUTE_ADDR: begin
				hit_route = 1'b1;
			end
			default: begin
				hit_upper = 1'b0;
			end
		endcase
	end

	assign mapped = hit_upper || hit_low || hit_mode || hit_route;
	assign read_only = hit_mode || hit_route;

	// the unlisted mode code falls back to single-chip: no pin reaches the bus by accident
	always_comb begin
		rom_on = 1'b0;
		rom_off = 1'b0;
		case (chip_mode)
			pdf_pkg::PDF_EXT_ROM_ON: begin
				rom_on = 1'b1;
			end
			pdf_pkg::PDF_EXT_ROM_OFF: begin
				rom_off = 1'b1;
			end
			default: begin
				rom_on = 1'b0;
				rom_off = 1'b0;
			end
		endcase
	end

	assign single = !(rom_on || rom_off);

	// function registers: next values
	always_comb begin
		next_upper = port_d_upper_mid_function;
		next_low = port_d_low_function;
		if (access && pwrite) begin
			case (paddr)
				pdf_pkg::UPPER_MID_ADDR: begin
					next_upper = pwdata[pdf_pkg::REG_WIDTH-1:0];
				end
				pdf_pkg::LOW_ADDR: begin
					next_low = pwdata[pdf_pkg::REG_WIDTH-1:0];
				end
				default: begin
					next_upper = port_d_upper_mid_function;
					next_low = port_d_low_function;
				end
			endcase
		end
	end

	// only the power-on reset clears them; no other reset reaches this block
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_d_upper_mid_function <= pdf_pkg::UPPER_MID_RESET;
			port_d_low_function <= pdf_pkg::LOW_RESET;
		end else begin
			port_d_upper_mid_function <= next_upper;
			port_d_low_function <= next_low;
		end
	end

	// bus response: ready in the access cycle, read data registered in setup
	always_comb begin
		next_prdata = prdata;
		next_pready = 1'b0;
		next_pslverr = 1'b0;
		if (setup) begin
			next_pready = 1'b1;
			next_pslverr = !mapped || (read_only && pwrite);
			case (paddr)
				pdf_pkg::UPPER_MID_ADDR: begin
					next_prdata = {16'h0000, port_d_upper_mid_function};
				end
				pdf_pkg::LOW_ADDR: begin
					next_prdata = {16'h0000, port_d_low_function};
				end
				pdf_pkg::MODE_ADDR: begin
					next_prdata = {30'h0000_0000, chip_mode};
				end
				pdf_pkg::ROUTE_ADDR: begin
					next_prdata = {8'h00, ext_int_line, low_route.bus_sel};
				end
				default: begin
					next_prdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// one decoder per upper pin; the loop index is the interrupt channel
	for (genvar i = 0; i < pdf_pkg::UPPER_PINS; i++) begin : g_upper
		pdf_upper_field pdf_upper_field_inst (
			.code(port_d_upper_mid_function[i*pdf_pkg::FIELD_WIDTH +: pdf_pkg::FIELD_WIDTH]),
			.single(single),
			.bus_sel(upper_bus[i]),
			.irq_sel(upper_irq[i])
		);
	end

	// one decoder per low pin
	for (genvar j = 0; j < pdf_pkg::LOW_PINS; j++) begin : g_low
		pdf_low_bit pdf_low_bit_inst (
			.func_bit(port_d_low_function[j]),
			.rom_on(rom_on),
			.rom_off(rom_off),
			.bus_sel(low_bus[j])
		);
	end

	// routing next values; unused upper struct bits stay zero
	always_comb begin
		next_upper_route = '0;
		next_low_route = '0;
		next_ext_int_line = 8'h00;
		for (int i = 0; i < pdf_pkg::UPPER_PINS; i++) begin
			next_upper_route.bus_sel[i] = upper_bus[i];
			next_upper_route.irq_sel[i] = upper_irq[i];
			next_ext_int_line[i] = upper_irq[i];
		end
		for (int j = 0; j < pdf_pkg::LOW_PINS; j++) begin
			next_low_route.bus_sel[j] = low_bus[j];
		end
	end

	// outputs registered, so routing trails a register or mode change by one clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_route <= '0;
			low_route <= '0;
			ext_int_line <= 8'h00;
		end else begin
			upper_route <= next_upper_route;
			low_route <= next_low_route;
			ext_int_line <= next_ext_int_line;
		end
	end

endmodule : pdf_pin_function

// one upper pin: 2-bit function code to bus or interrupt use
module pdf_upper_field (
	// function code and mode
	input wire logic [1:0] code,
	input wire logic single,
	// pin use
	output logic bus_sel,
	output logic irq_sel
);

	always_comb begin
		bus_sel = 1'b0;
		irq_sel = 1'b0;
		case (code)
			pdf_pkg::CODE_GPIO: begin
				bus_sel = 1'b0;
				irq_sel = 1'b0;
			end
			pdf_pkg::CODE_BUS: begin
				// single-chip mode keeps the pin as general I/O
				bus_sel = !single;
			end
			pdf_pkg::CODE_IRQ: begin
				irq_sel = 1'b1;
			end
			pdf_pkg::CODE_RSVD: begin
				// reserved code parks the pin as general I/O
				bus_sel = 1'b0;
				irq_sel = 1'b0;
			end
			default: begin
				bus_sel = 1'b0;
				irq_sel = 1'b0;
			end
		endcase
	end

endmodule : pdf_upper_field

// one low pin: mode decides whether the function bit counts
module pdf_low_bit (
	// function bit and mode
	input wire logic func_bit,
	input wire logic rom_on,
	input wire logic rom_off,
	// pin use
	output logic bus_sel
);

	always_comb begin
		bus_sel = 1'b0;
		if (rom_off) begin
			// the bus needs these pins whatever the register holds
			bus_sel = 1'b1;
		end else if (rom_on) begin
			bus_sel = func_bit;
		end else begin
			bus_sel = 1'b0;
		end
	end

endmodule : pdf_low_bit
`default_nettype wire

// ---- hdl/pdf_pkg.sv ----
/*
 * pdf_pkg: constants and types for the port pin function select block.
 * assumes an APB register slave with 32-bit data, one aligned word per register.
 */
package pdf_pkg;

	// register byte addresses
	localparam logic [7:0] UPPER_MID_ADDR = 8'h00;
	localparam logic [7:0] LOW_ADDR = 8'h04;
	localparam logic [7:0] MODE_ADDR = 8'h08;
	localparam logic [7:0] ROUTE_ADDR = 8'h0c;

	// reset values
	localparam logic [15:0] UPPER_MID_RESET = 16'h0000;
	localparam logic [15:0] LOW_RESET = 16'h0000;

	// field layout
	localparam int UPPER_PINS = 8;
	localparam int LOW_PINS = 16;
	localparam int FIELD_WIDTH = 2;
	localparam int REG_WIDTH = 16;

	// 2-bit function codes
	localparam logic [1:0] CODE_GPIO = 2'h0;
	localparam logic [1:0] CODE_BUS = 2'h1;
	localparam logic [1:0] CODE_IRQ = 2'h2;
	localparam logic [1:0] CODE_RSVD = 2'h3;

	// chip operating modes
	typedef enum logic [1:0] {
		PDF_SINGLE_CHIP = 2'h0,
		PDF_EXT_ROM_ON = 2'h1,
		PDF_EXT_ROM_OFF = 2'h3
	} pdf_mode_type;

	// pin routing for one 16-pin half
	typedef struct packed {
		logic [15:0] bus_sel;
		logic [15:0] irq_sel;
	} pdf_route_type;

endpackage : pdf_pkg
